// [verilog/tbd_pkg.sv]
`default_nettype none
package tbd_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // clock and blink timing
    localparam int CLK_HZ        = 100000000;
    localparam int CYC_PER_MS    = CLK_HZ / 1000;
    localparam int FAST_HALF_MS  = 50;
    localparam int SLOW_HALF_MS  = 250;
    localparam int PAUSE_MS      = 1000;
    localparam int FAST_HALF_CYC = FAST_HALF_MS * CYC_PER_MS;
    localparam int SLOW_HALF_CYC = SLOW_HALF_MS * CYC_PER_MS;
    localparam int PAUSE_CYC     = PAUSE_MS * CYC_PER_MS;
    localparam int TMR_W         = 27;
    localparam logic [3:0] FAST_PULSES = 4'h8;

    ////////////////////////////////////////////////////////////////////////////
    // register map (byte addresses) and fields
    localparam logic [7:0] OFS_STATUS = 8'h00;
    localparam logic [7:0] OFS_CTRL   = 8'h04;
    localparam logic [7:0] OFS_DIAG   = 8'h08;
    localparam int CTRL_DEV_RESET_BIT = 0;
    localparam int ST_BUS_ERR   = 0;
    localparam int ST_CFG_CHG   = 1;
    localparam int ST_PI_LEN    = 2;
    localparam int ST_NO_INPUT  = 8;
    localparam int ST_IN_UPD    = 9;
    localparam int ST_OUT_UPD   = 10;
    localparam int ST_WATCHDOG  = 11;
    localparam int ST_ACYCLIC   = 15;
    localparam logic [15:0] STATUS_RST = 16'h0000;
    localparam logic [31:0] RDATA_RST  = 32'h0000_0000;

    ////////////////////////////////////////////////////////////////////////////
    // blink-code values
    localparam logic [2:0] CODE_CMD      = 3'h3;
    localparam logic [2:0] CODE_BREAK    = 3'h4;
    localparam logic [2:0] CODE_REGCOM   = 3'h5;
    localparam logic [2:0] CODE_INTERNAL = 3'h6;
    localparam logic [2:0] CODE_PDLEN    = 3'h7;
    localparam logic [5:0] ARG_ZERO      = 6'h00;
    localparam logic [5:0] ARG_INT_A     = 6'h01;
    localparam logic [5:0] ARG_INT_B     = 6'h08;
    localparam int SLOTS = 32;

    ////////////////////////////////////////////////////////////////////////////
    // types
    typedef enum logic [2:0] {FK_CMD, FK_BREAK, FK_REGCOM, FK_INIT, FK_INTERNAL, FK_PDLEN}
        tbd_kind_t;

    typedef struct packed {
        logic      valid;
        tbd_kind_t kind;
        logic      at_supply;
        logic      alt_arg;
        logic [4:0] slot;
    } tbd_fault_t;

    typedef struct packed {
        logic cfg_changed;
        logic pi_mismatch;
        logic no_valid_inputs;
        logic in_upd_busy;
        logic out_upd_busy;
        logic watchdog;
        logic acyclic_busy;
    } tbd_stat_t;

    typedef struct packed {
        logic        hsel;
        logic [31:0] haddr;
        logic [1:0]  htrans;
        logic        hwrite;
        logic [2:0]  hsize;
    } tbd_ahb_req_t;

endpackage
`default_nettype wire

// [verilog/tbd_diag.sv]
// How it works
// - error led stays dark without a terminal error and flashes when one exists
// - run led lit only when error-free and the fieldbus is running
// - error led flashes at a fast and a slow rate
// - sequence: fast burst, slow code pulses, dark pause, slow argument pulses
// - argument pulse count equals position of last terminal before the fault
// - passive terminals are skipped when counting positions
// - command error or no terminal: code 3, argument 0
// - data error or break: code 4, argument 0 at supply or terminal n
// - register communication failure with terminal n: code 5, argument n
// - internal faults: code 6, argument 0 init, 1 or 8 data error
// - process data length mismatch: code 7, argument 0
// - internal faults stay latched until power is cycled
// - status word reads zero only when bus is synchronous and error-free
// - nonzero status may come from update lag without a real fault
// - status bits 0, 1, 2: bus error, config changed, image length mismatch
// - status bits 8..11: no inputs, input busy, output busy, watchdog
// - status bit 15 while an acyclic bus function runs
// - a device reset request clears a latched bus error
// - link led off unconnected, on when idle, flashing with traffic
//
// The placing of the registers and register access over AHB-Lite were chosen for this implementation.
`default_nettype none
module tbd_diag
    import tbd_pkg::*;
#(
    parameter logic [TMR_W-1:0] FAST_HALF = TMR_W'(FAST_HALF_CYC),
    parameter logic [TMR_W-1:0] SLOW_HALF = TMR_W'(SLOW_HALF_CYC),
    parameter logic [TMR_W-1:0] PAUSE_LEN = TMR_W'(PAUSE_CYC)
)(
    // clock, reset, enable
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic         ce,
    // ahb-lite slave
    input  wire tbd_ahb_req_t ahb_req,
    input  wire logic [31:0]  hwdata,
    input  wire logic         hready,
    output logic              hreadyout,
    output logic              hresp,
    output logic [31:0]       hrdata,
    // terminal chain diagnostics
    input  wire tbd_fault_t   fault,
    input  wire logic [31:0]  passive_mask,
    input  wire tbd_stat_t    bus_stat,
    input  wire logic         fieldbus_run,
    // second bus pins
    input  wire logic         link_pin,
    input  wire logic         act_pin,
    // leds
    output logic              run_led,
    output logic              err_led,
    output logic              link_led
);

    typedef enum {ST_IDLE, ST_START, ST_CODE, ST_PAUSE, ST_ARG, ST_GAP} tbd_state_t;

    ////////////////////////////////////////////////////////////////////////////
    // position count over active terminals
    function automatic logic [5:0] count_active(input logic [31:0] pmask,
                                                input logic [4:0] slot);
        logic [5:0] cnt;
        cnt = 6'h00;
        for (int i = 0; i < SLOTS; i++)
        begin
            if (i <= int'(slot) && !pmask[i])
                cnt = cnt + 6'h01;
        end
        return cnt;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers, change accepted once stages 2 and 3 agree
    logic [1:0] pin_s1_ff;
    logic [1:0] pin_s2_ff;
    logic [1:0] pin_s3_ff;
    logic [1:0] pin_q_ff;
    wire  [1:0] pin_raw = {act_pin, link_pin};

    genvar g;
    generate
        for (g = 0; g < 2; g++)
        begin : g_sync
            always_ff @(posedge clk)
            begin
                if (!rst_n)
                begin
                    pin_s1_ff[g] <= 1'b0;
                    pin_s2_ff[g] <= 1'b0;
                    pin_s3_ff[g] <= 1'b0;
                    pin_q_ff[g]  <= 1'b0;
                end
                else if (ce)
                begin
                    pin_s1_ff[g] <= pin_raw[g];
                    pin_s2_ff[g] <= pin_s1_ff[g];
                    pin_s3_ff[g] <= pin_s2_ff[g];
                    if (pin_s2_ff[g] == pin_s3_ff[g])
                        pin_q_ff[g] <= pin_s3_ff[g];
                end
            end
        end
    endgenerate

    wire link_q = pin_q_ff[0];
    wire act_q  = pin_q_ff[1];

    ////////////////////////////////////////////////////////////////////////////
    // fault decode into code and argument
    wire [5:0] pos_arg = count_active(passive_mask, fault.slot);
    logic [2:0] f_code;
    logic [5:0] f_arg;
    logic       f_sticky;
    logic       f_latch;
    always_comb
    begin
        f_code   = CODE_CMD;
        f_arg    = ARG_ZERO;
        f_sticky = 1'b0;
        f_latch  = 1'b0;
        case (fault.kind)
            FK_CMD:      f_code = CODE_CMD;
            FK_BREAK:
            begin
                f_code  = CODE_BREAK;
                f_arg   = fault.at_supply ? ARG_ZERO : pos_arg;
                f_latch = 1'b1;
            end
            FK_REGCOM:
            begin
                f_code  = CODE_REGCOM;
                f_arg   = pos_arg;
                f_latch = 1'b1;
            end
            FK_INIT:
            begin
                f_code   = CODE_INTERNAL;
                f_sticky = 1'b1;
            end
            FK_INTERNAL:
            begin
                f_code   = CODE_INTERNAL;
                f_arg    = fault.alt_arg ? ARG_INT_B : ARG_INT_A;
                f_sticky = 1'b1;
            end
            FK_PDLEN:    f_code = CODE_PDLEN;
            default:     f_code = CODE_CMD;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // error latch
    logic       err_active_ff;
    logic       err_sticky_ff;
    logic       err_hold_ff;
    logic [2:0] err_code_ff;
    logic [5:0] err_arg_ff;
    logic       dev_rst_ff;

    wire err_release = !err_sticky_ff && (!err_hold_ff || dev_rst_ff);

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            err_active_ff <= 1'b0;
            err_sticky_ff <= 1'b0;
            err_hold_ff   <= 1'b0;
            err_code_ff   <= 3'h0;
            err_arg_ff    <= 6'h00;
        end
        else if (ce)
        begin
            if (fault.valid)
            begin
                err_active_ff <= 1'b1;
                err_sticky_ff <= err_sticky_ff | f_sticky;
                err_hold_ff   <= err_hold_ff | f_latch;
                err_code_ff   <= f_code;
                err_arg_ff    <= f_arg;
            end
            else if (err_release)
            begin
                err_active_ff <= 1'b0;
                err_hold_ff   <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // blink sequencer
    tbd_state_t       state_ff;
    tbd_state_t       nxt_state;
    logic [TMR_W-1:0] tmr_ff;
    logic [TMR_W-1:0] nxt_tmr;
    logic             half_ff;
    logic             nxt_half;
    logic [5:0]       pcnt_ff;
    logic [5:0]       nxt_pcnt;
    logic [2:0]       cap_code_ff;
    logic [2:0]       nxt_cap_code;
    logic [5:0]       cap_arg_ff;
    logic [5:0]       nxt_cap_arg;

    wire tmr_done = (tmr_ff == '0);
    wire pulsing  = (state_ff == ST_START) || (state_ff == ST_CODE) || (state_ff == ST_ARG);
    wire [TMR_W-1:0] half_len = (state_ff == ST_START) ? FAST_HALF : SLOW_HALF;

    always_comb
    begin
        nxt_state    = state_ff;
        nxt_tmr      = tmr_done ? tmr_ff : tmr_ff - 1'b1;
        nxt_half     = half_ff;
        nxt_pcnt     = pcnt_ff;
        nxt_cap_code = cap_code_ff;
        nxt_cap_arg  = cap_arg_ff;
        if (!err_active_ff)
        begin
            nxt_state = ST_IDLE;
            nxt_half  = 1'b0;
        end
        else if (state_ff == ST_IDLE)
        begin
            nxt_state    = ST_START;
            nxt_tmr      = FAST_HALF - 1'b1;
            nxt_half     = 1'b0;
            nxt_pcnt     = {2'b00, FAST_PULSES} - 6'h01;
            nxt_cap_code = err_code_ff;
            nxt_cap_arg  = err_arg_ff;
        end
        else if (tmr_done)
        begin
            if (pulsing && !half_ff)
            begin
                nxt_half = 1'b1;
                nxt_tmr  = half_len - 1'b1;
            end
            else if (pulsing && pcnt_ff != 6'h00)
            begin
                nxt_half = 1'b0;
                nxt_pcnt = pcnt_ff - 6'h01;
                nxt_tmr  = half_len - 1'b1;
            end
            else
            begin
                nxt_half = 1'b0;
                case (state_ff)
                    ST_START:
                    begin
                        nxt_state = ST_CODE;
                        nxt_pcnt  = {3'b000, cap_code_ff} - 6'h01;
                        nxt_tmr   = SLOW_HALF - 1'b1;
                    end
                    ST_CODE:
                    begin
                        nxt_state = ST_PAUSE;
                        nxt_tmr   = PAUSE_LEN - 1'b1;
                    end
                    ST_PAUSE:
                    begin
                        nxt_state = (cap_arg_ff == ARG_ZERO) ? ST_GAP : ST_ARG;
                        nxt_pcnt  = cap_arg_ff - 6'h01;
                        nxt_tmr   = (cap_arg_ff == ARG_ZERO) ? PAUSE_LEN - 1'b1
                                                             : SLOW_HALF - 1'b1;
                    end
                    ST_ARG:
                    begin
                        nxt_state = ST_GAP;
                        nxt_tmr   = PAUSE_LEN - 1'b1;
                    end
                    ST_GAP:  nxt_state = ST_IDLE;
                    default: nxt_state = ST_IDLE;
                endcase
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            state_ff    <= ST_IDLE;
            tmr_ff      <= '0;
            half_ff     <= 1'b0;
            pcnt_ff     <= 6'h00;
            cap_code_ff <= 3'h0;
            cap_arg_ff  <= 6'h00;
        end
        else if (ce)
        begin
            state_ff    <= nxt_state;
            tmr_ff      <= nxt_tmr;
            half_ff     <= nxt_half;
            pcnt_ff     <= nxt_pcnt;
            cap_code_ff <= nxt_cap_code;
            cap_arg_ff  <= nxt_cap_arg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // status word and leds
    logic [15:0] status_ff;
    logic [15:0] nxt_status;
    logic        wdog_ff;
    logic [TMR_W-1:0] act_tmr_ff;
    logic        act_ph_ff;
    logic        run_led_ff;
    logic        err_led_ff;
    logic        link_led_ff;

    always_comb
    begin
        nxt_status              = STATUS_RST;
        nxt_status[ST_BUS_ERR]  = err_active_ff;
        nxt_status[ST_CFG_CHG]  = bus_stat.cfg_changed;
        nxt_status[ST_PI_LEN]   = bus_stat.pi_mismatch;
        nxt_status[ST_NO_INPUT] = bus_stat.no_valid_inputs;
        nxt_status[ST_IN_UPD]   = bus_stat.in_upd_busy;
        nxt_status[ST_OUT_UPD]  = bus_stat.out_upd_busy;
        nxt_status[ST_WATCHDOG] = wdog_ff;
        nxt_status[ST_ACYCLIC]  = bus_stat.acyclic_busy;
    end

    wire act_tick = (act_tmr_ff == '0);

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            status_ff   <= STATUS_RST;
            wdog_ff     <= 1'b0;
            act_tmr_ff  <= '0;
            act_ph_ff   <= 1'b0;
            run_led_ff  <= 1'b0;
            err_led_ff  <= 1'b0;
            link_led_ff <= 1'b0;
        end
        else if (ce)
        begin
            status_ff   <= nxt_status;
            wdog_ff     <= bus_stat.watchdog | (wdog_ff & !dev_rst_ff);
            act_tmr_ff  <= act_tick ? FAST_HALF - 1'b1 : act_tmr_ff - 1'b1;
            act_ph_ff   <= act_tick ? !act_ph_ff : act_ph_ff;
            run_led_ff  <= fieldbus_run && !err_active_ff && (status_ff == STATUS_RST);
            err_led_ff  <= err_active_ff && pulsing && !half_ff;
            link_led_ff <= link_q && (!act_q || act_ph_ff);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // ahb-lite slave, zero wait states
    logic        wr_pend_ff;
    logic [7:0]  wr_addr_ff;
    logic [31:0] hrdata_ff;
    logic        hreadyout_ff;

    wire        ahb_take = ahb_req.hsel && ahb_req.htrans[1] && hready;
    wire [7:0]  ahb_ofs  = ahb_req.haddr[7:0];
    wire        ahb_hit  = (ahb_req.haddr[31:8] == 24'h00_0000);
    wire [31:0] diag_word = {18'h0_0000, link_led_ff, err_led_ff, run_led_ff,
                             err_sticky_ff, err_active_ff, err_code_ff, err_arg_ff};
    wire [31:0] rd_mux = !ahb_hit               ? RDATA_RST :
                         (ahb_ofs == OFS_STATUS) ? {16'h0000, status_ff} :
                         (ahb_ofs == OFS_DIAG)   ? diag_word : RDATA_RST;

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            wr_pend_ff   <= 1'b0;
            wr_addr_ff   <= 8'h00;
            hrdata_ff    <= RDATA_RST;
            hreadyout_ff <= 1'b1;
            dev_rst_ff   <= 1'b0;
        end
        else if (ce)
        begin
            hreadyout_ff <= 1'b1;
            wr_pend_ff   <= ahb_take && ahb_req.hwrite && ahb_hit;
            wr_addr_ff   <= ahb_ofs;
            hrdata_ff    <= (ahb_take && !ahb_req.hwrite) ? rd_mux : hrdata_ff;
            dev_rst_ff   <= wr_pend_ff && (wr_addr_ff == OFS_CTRL)
                            && hwdata[CTRL_DEV_RESET_BIT];
        end
    end

    assign hreadyout = hreadyout_ff;
    assign hresp     = 1'b0;
    assign hrdata    = hrdata_ff;
    assign run_led   = run_led_ff;
    assign err_led   = err_led_ff;
    assign link_led  = link_led_ff;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    chk_err_led_dark: assert property (ce && !err_active_ff |=> !err_led_ff)
        else $error("error led lit without error");
    chk_run_led_excl: assert property (err_led_ff |-> !run_led_ff)
        else $error("run and error leds lit together");
    chk_fast_half_len: assert property (ce && err_active_ff && state_ff == ST_START
        && tmr_done && !half_ff |=> half_ff && tmr_ff == FAST_HALF - 1'b1)
        else $error("fast half period wrong");
    chk_code_after_start: assert property (ce && state_ff == ST_START
        && err_active_ff && nxt_state != ST_START |=> state_ff == ST_CODE)
        else $error("code phase does not follow start burst");
    chk_arg_position: assert property (ce && fault.valid && fault.kind == FK_REGCOM
        && (passive_mask & ((32'h0000_0002 << fault.slot) - 32'h0000_0001)) == 32'h0000_0000
        |=> err_arg_ff == {1'b0, $past(fault.slot)} + 6'h01)
        else $error("argument not terminal position");
    chk_arg_passive: assert property (ce && fault.valid && !fault.at_supply
        && (fault.kind == FK_REGCOM || fault.kind == FK_BREAK)
        |=> err_arg_ff == 6'(int'($past(fault.slot)) + 1 - $countones($past(passive_mask)
            & ((32'h0000_0002 << $past(fault.slot)) - 32'h0000_0001))))
        else $error("passive terminal counted");
    chk_cmd_code: assert property (ce && fault.valid && fault.kind == FK_CMD
        |=> err_code_ff == CODE_CMD && err_arg_ff == ARG_ZERO)
        else $error("command error code wrong");
    chk_sticky_hold: assert property (ce && err_sticky_ff |=> err_active_ff)
        else $error("internal fault cleared before power cycle");
    chk_dev_reset_clear: assert property (ce && dev_rst_ff && !fault.valid
        && !err_sticky_ff |=> !err_active_ff)
        else $error("device reset did not clear error");
    chk_status_bit0: assert property (ce && err_active_ff |=> status_ff[ST_BUS_ERR])
        else $error("bus error bit missing");
    chk_link_off: assert property (ce && !link_q |=> !link_led_ff)
        else $error("link led lit while unconnected");
    chk_capture_hold: assert property (ce && state_ff != ST_IDLE && nxt_state != ST_IDLE
        |=> $stable(cap_code_ff))
        else $error("code changed during playback");

    cov_arg_phase: cover property (state_ff == ST_ARG);
    cov_repeat:    cover property (state_ff == ST_GAP ##1 state_ff == ST_IDLE);
    cov_dev_reset: cover property (dev_rst_ff && err_active_ff);

endmodule
`default_nettype wire

// [tb/tbd_chain.sv]
`default_nettype none
module tbd_chain
    import tbd_pkg::*;
#(
    parameter logic [31:0] PASSIVE = 32'h0000_0004
)(
    // clock
    input  wire logic       clk,
    // bench commands
    input  wire tbd_fault_t flt_cmd,
    input  wire tbd_stat_t  stat_cmd,
    input  wire logic       link_cmd,
    input  wire logic       act_cmd,
    // toward the block
    output tbd_fault_t      fault,
    output logic [31:0]     passive_mask,
    output tbd_stat_t       bus_stat,
    output logic            link_pin,
    output logic            act_pin
);
    timeunit 1ns;
    timeprecision 1ps;

    ////////////////////////////////////////////////////////////////////////////
    // power feed terminal sits in slot 2
    assign passive_mask = PASSIVE;

    // chain reports its state one clock after a command
    always_ff @(posedge clk)
    begin
        fault    <= flt_cmd;
        bus_stat <= stat_cmd;
        link_pin <= link_cmd;
        act_pin  <= act_cmd;
    end
endmodule
`default_nettype wire

// [tb/tbd_diag_bench.sv]
`default_nettype none
module tbd_diag_bench
    import tbd_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int FH = 4;
    localparam int SH = 8;
    localparam int PL = 12;
    logic         clk = 0;
    logic         rst_n = 0;
    logic         fb_run = 0;
    logic         link = 0;
    logic         act = 0;
    tbd_ahb_req_t req = '0;
    tbd_fault_t   flt = '0;
    tbd_stat_t    st = '0;
    logic [31:0]  hwdata = '0;
    logic [31:0]  hrdata, rd, passive_mask;
    logic         hreadyout, hresp, run_led, err_led, link_led, link_pin, act_pin;
    tbd_fault_t   fault;
    tbd_stat_t    bus_stat;
    int           mismatches = 0;
    int           checks = 0;

    ////////////////////////////////////////////////////////////////////////////
    tbd_chain chain (.clk(clk), .flt_cmd(flt), .stat_cmd(st), .link_cmd(link),
        .act_cmd(act), .fault(fault), .passive_mask(passive_mask), .bus_stat(bus_stat),
        .link_pin(link_pin), .act_pin(act_pin));
    tbd_diag #(.FAST_HALF(TMR_W'(FH)), .SLOW_HALF(TMR_W'(SH)), .PAUSE_LEN(TMR_W'(PL))) uut (
        .clk(clk), .rst_n(rst_n), .ce(1'b1), .ahb_req(req), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .fault(fault), .passive_mask(passive_mask), .bus_stat(bus_stat),
        .fieldbus_run(fb_run), .link_pin(link_pin), .act_pin(act_pin),
        .run_led(run_led), .err_led(err_led), .link_led(link_led));
    always #5 clk = ~clk;

    ////////////////////////////////////////////////////////////////////////////
    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic hold(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic rdy();
        int n;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (hreadyout !== 1'b1 && n < 50);
        if (hreadyout !== 1'b1)
        begin
            mismatches++;
            stop_test();
        end
    endtask

    // single word transfer, read data left in rd
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        req <= '{1'b1, {24'h0, a}, 2'h2, wr, 3'h2};
        rdy();
        req <= '0;
        hwdata <= wd;
        rdy();
        rd = hrdata;
    endtask

    task automatic dev_reset();
        bus(1'b1, OFS_CTRL, 32'h1);
        hold(4);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        chk(32'({run_led, err_led, link_led}), 32'h0);
        bus(1'b0, OFS_STATUS, 32'h0);
        chk(rd, 32'h0);
        chk(32'({hresp, hreadyout}), 32'h1);
        bus(1'b0, OFS_CTRL, 32'h0);
        chk(rd, 32'h0);
        bus(1'b0, 8'h40, 32'h0);
        chk(rd, 32'h0);
    endtask

    task automatic t_status();
        fb_run <= 1'b1;
        st <= '1;
        hold(4);
        bus(1'b0, OFS_STATUS, 32'h0);
        chk(rd, 32'h0000_8F06);
        chk(32'(run_led), 32'h0);
        st <= '0;
        hold(4);
        bus(1'b0, OFS_STATUS, 32'h0);
        chk(rd, 32'h0000_0800);
        dev_reset();
        bus(1'b0, OFS_STATUS, 32'h0);
        chk(rd, 32'h0);
        chk(32'(run_led), 32'h1);
        fb_run <= 1'b0;
        hold(3);
        chk(32'(run_led), 32'h0);
    endtask

    task automatic t_code(input tbd_kind_t k, input logic sup, input logic alt,
                          input logic [4:0] s, input logic [2:0] c, input logic [5:0] a);
        logic lat;
        logic keep;
        lat = k inside {FK_BREAK, FK_REGCOM, FK_INIT, FK_INTERNAL};
        keep = k inside {FK_INIT, FK_INTERNAL};
        flt <= '{1'b1, k, sup, alt, s};
        hold(4);
        bus(1'b0, OFS_DIAG, 32'h0);
        chk(32'(rd[9:0]), 32'({1'b1, c, a}));
        bus(1'b0, OFS_STATUS, 32'h0);
        chk(32'(rd[0]), 32'h1);
        flt <= '0;
        hold(4);
        bus(1'b0, OFS_DIAG, 32'h0);
        chk(32'(rd[9]), 32'(lat));
        dev_reset();
        bus(1'b0, OFS_DIAG, 32'h0);
        chk(32'(rd[9]), 32'(keep));
        rst_n <= 1'b0;
        hold(2);
        rst_n <= 1'b1;
        hold(2);
        chk(32'(err_led), 32'h0);
    endtask

    task automatic run_len(input logic lvl, output int n);
        n = 0;
        while (err_led === lvl && n < 200)
        begin
            @(posedge clk);
            n++;
        end
    endtask

    task automatic t_blink(input tbd_kind_t k, input logic [4:0] s, input int c, input int a);
        int n;
        int m;
        int lo;
        flt <= '{1'b1, k, 1'b0, 1'b0, s};
        run_len(1'b0, n);
        for (int i = 0; i < 8 + c + a; i++)
        begin
            run_len(1'b1, n);
            run_len(1'b0, m);
            lo = (i < 8) ? FH : SH;
            lo += PL * (int'(i == 7 + c) + int'(i == 7 + c + a));
            chk(n, (i < 8) ? FH : SH);
            chk(32'(m >= lo && m <= lo + 2), 32'h1);
        end
        flt <= '0;
        dev_reset();
        chk(32'(err_led), 32'h0);
    endtask

    task automatic t_link();
        int n;
        logic prev;
        link <= 1'b1;
        hold(8);
        chk(32'(link_led), 32'h1);
        act <= 1'b1;
        hold(8);
        n = 0;
        prev = link_led;
        repeat (4 * FH)
        begin
            @(posedge clk);
            n += int'(link_led !== prev);
            prev = link_led;
        end
        chk(32'(n >= 3), 32'h1);
        act <= 1'b0;
        hold(8);
        chk(32'(link_led), 32'h1);
        link <= 1'b0;
        hold(8);
        chk(32'(link_led), 32'h0);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        hold(2);
        rst_n <= 1'b1;
        hold(1);
        t_reset();
        $display("reset test done");
        t_status();
        $display("status test done");
        t_code(FK_CMD, 1'b0, 1'b0, 5'h00, 3'h3, 6'h00);
        t_code(FK_BREAK, 1'b1, 1'b0, 5'h04, 3'h4, 6'h00);
        t_code(FK_BREAK, 1'b0, 1'b0, 5'h05, 3'h4, 6'h05);
        t_code(FK_REGCOM, 1'b0, 1'b0, 5'h01, 3'h5, 6'h02);
        t_code(FK_INIT, 1'b0, 1'b0, 5'h00, 3'h6, 6'h00);
        t_code(FK_INTERNAL, 1'b0, 1'b0, 5'h00, 3'h6, 6'h01);
        t_code(FK_INTERNAL, 1'b0, 1'b1, 5'h00, 3'h6, 6'h08);
        t_code(FK_PDLEN, 1'b0, 1'b0, 5'h00, 3'h7, 6'h00);
        $display("code test done");
        t_blink(FK_CMD, 5'h00, 3, 0);
        t_blink(FK_BREAK, 5'h01, 4, 2);
        $display("blink test done");
        t_link();
        $display("link test done");
        stop_test();
    end
endmodule
`default_nettype wire
